// [logic/dfsh_cfg.svh]
`ifndef DFSH_CFG_SVH
`define DFSH_CFG_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define DFSH_CLK_HZ         100000000
`define DFSH_MS_CYC         (`DFSH_CLK_HZ / 1000)
`define DFSH_UV_TIME_MS     25
`define DFSH_UV_CYC         (`DFSH_MS_CYC * `DFSH_UV_TIME_MS)
`define DFSH_LF_HZ          47
`define DFSH_LF_CYC         (`DFSH_CLK_HZ / `DFSH_LF_HZ)
`define DFSH_OF_HZ          63
`define DFSH_OF_CYC         (`DFSH_CLK_HZ / `DFSH_OF_HZ)
`define DFSH_DROP_MS        8'h0a
`define DFSH_OVLD_TIME_MS   16'h03e8
`define DFSH_ACC_DECAY_MS   10'h3e8
`define DFSH_ACC_MAX        3'h4

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define DFSH_REG_CTRL       8'h00
`define DFSH_REG_BLK_TIME   8'h01
`define DFSH_REG_BLK_CUR    8'h02
`define DFSH_REG_STATUS     8'h03
`define DFSH_REG_MSG        8'h04
`define DFSH_REG_WARN       8'h05
`define DFSH_REG_FAULT      8'h06
`define DFSH_REG_INH_DISP   8'h07
`define DFSH_REG_HIST_FIRST 8'h10
`define DFSH_REG_HIST_LAST  8'h17

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define DFSH_CTRL_LINK_CHK  0
`define DFSH_CTRL_EXT_POL   1
`define DFSH_CTRL_ACK       2
`define DFSH_RST_BLK_TIME   16'h01f4
`define DFSH_RST_BLK_CUR    12'h800

// ----------------------------------------------------------------
// numeric fault numbers
// ----------------------------------------------------------------
`define DFSH_FC_NONE        8'h00
`define DFSH_FC_UNDERFREQ   8'h01
`define DFSH_FC_OVERFREQ    8'h02
`define DFSH_FC_UNDERVOLT   8'h03
`define DFSH_FC_EXT_TRIP    8'h04
`define DFSH_FC_OVERLOAD    8'h05
`define DFSH_FC_BLOCKED     8'h06

`endif

// [logic/dfsh_pkg.sv]
package dfsh_pkg;

  // ----------------------------------------------------------------
  // pins from outside the clock domain
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       ctrl_enable_sw;  // enable switch closed
    logic       torque_ok;       // machine produces torque
    logic       supply_loss;     // control supply switched off
    logic       link_up;         // automation module talking
    logic       field_ok;        // field current built up
    logic       param_load;      // parameter set load via terminal
    logic       trip_reset;      // terminal trip reset
    logic       ext_trip;        // external trip input
    logic       zero_cross;      // mains zero crossing, once a period
    logic       mains_uv;        // mains undervoltage flagged
    logic       mains_ov;        // mains overvoltage flagged
    logic       speed_at_limit;  // speed controller saturated
    logic       oc_accel;        // overcurrent acceleration
    logic       over_rated;      // armature current above 1.05 rated
    logic       standstill;      // motor at standstill
    logic [2:0] inhibit_src;     // other inhibit sources
  } dfsh_pins_t;

  // trip latch states
  typedef enum logic {
    DFSH_T_OK,
    DFSH_T_TRIPPED
  } dfsh_trip_st_t;

  // ----------------------------------------------------------------
  // whole module state
  // ----------------------------------------------------------------
  typedef struct packed {
    dfsh_pins_t      p1, p2, p3;  // sync stages and edge history
    logic [21:0]     per_cnt;     // mains period counter
    logic            lf, of, uv;  // mains message flags
    logic [16:0]     ms_cnt;      // millisecond prescaler
    logic [15:0]     blk_ms;      // blocking time elapsed
    logic [15:0]     ovl_ms;      // sustained overload time
    logic [2:0]      acc_cnt;     // recent overcurrent accelerations
    logic [9:0]      acc_dec;     // decay timer
    dfsh_trip_st_t   trip_st;
    logic [7:0]      trip_code;
    logic [7:0]      msg_code;
    logic            link_seen, field_built;
    logic [7:0]      drop_ms;     // ready drop timer
    logic [7:0][7:0] hist;        // history, [0] newest
    logic            link_chk, ext_pol;
    logic [15:0]     blk_time;
    logic [11:0]     blk_cur;
    logic [15:0]     rdata;
    logic            ready, inhibit, cur_lim, fail;
    logic [5:0]      fire;
    logic [7:0]      inh_disp;
  } dfsh_state_t;

endpackage

// [logic/dfsh_top.sv]
`timescale 1ns/1ps
`include "dfsh_cfg.svh"
// Behaviour
// [RULE_01] ready drops: no torque or supply lost; no torque drops ready only while the enable switch is closed
// [RULE_02] with link check, ready waits for link
// [RULE_03] ready waits until field current built
// [RULE_04] ready drops briefly on parameter load
// [RULE_05] ready drops briefly on mains interruption
// [RULE_06] current limit flag follows speed saturation
// [RULE_07] inhibit on open switch or other source
// [RULE_08] inhibit during mains under or overvoltage
// [RULE_09] no ignition pulses while inhibited
// [RULE_10] message, warning, trip and status readable
// [RULE_11] eight history entries, newest first
// [RULE_12] history readable at eight consecutive addresses
// [RULE_13] history written only after fault cleared
// [RULE_14] oldest entry lost on each new entry
// [RULE_15] faults read back as numeric codes
// [RULE_16] underfrequency below 47 Hz
// [RULE_17] overfrequency above 63 Hz
// [RULE_18] undervoltage after 25 ms without zero crossing
// [RULE_19] external trip, polarity selectable
// [RULE_20] overload on accelerations or sustained overcurrent
// [RULE_21] blocked after standstill current exceeds time
// [RULE_22] trip released only by accepted acknowledge
// [RULE_23] messages release inhibit automatically
// [RULE_24] history shifts and stores in one cycle
// [RULE_25] history cleared to no fault on reset
module dfsh_top #(
  parameter int unsigned P_MS_CYC = `DFSH_MS_CYC,
  parameter int unsigned P_UV_CYC = `DFSH_UV_CYC,
  parameter int unsigned P_LF_CYC = `DFSH_LF_CYC,
  parameter int unsigned P_OF_CYC = `DFSH_OF_CYC
) (
  input  wire logic               i_clock,
  input  wire logic               i_rst,
  input  wire dfsh_pkg::dfsh_pins_t i_pins,
  input  wire logic [11:0]        i_arm_current,
  input  wire logic [5:0]         i_fire,
  input  wire logic [7:0]         i_addr,
  input  wire logic [15:0]        i_wdata,
  input  wire logic               i_wr,
  input  wire logic               i_rd,
  output logic [15:0]             o_rdata,
  output logic                    o_drive_ready,
  output logic                    o_pulse_inhibit,
  output logic                    o_current_limit_flag,
  output logic                    o_fault_active,
  output logic [5:0]              o_fire
);

  // ----------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------
  dfsh_pkg::dfsh_state_t s_q;           // registered state
  dfsh_pkg::dfsh_state_t s_d;           // next state
  logic                  ms_tick;       // one per millisecond
  logic                  zc_edge;       // zero crossing seen
  logic                  param_edge;    // parameter load edge
  logic                  ack;           // acknowledge request
  logic                  ext_act;       // external trip active
  logic                  ovl_trip;      // overload condition
  logic                  blk_cond;      // standstill overcurrent
  logic                  blk_trip;      // blocking condition
  logic                  trip_src_any;  // any trip source
  logic [7:0]            trip_new;      // code of new trip
  logic [7:0]            msg_now;       // current message code
  logic [7:0]            warn_now;      // current warning code
  logic                  hist_wr;       // history write
  logic [7:0]            wr_code;       // code to record
  logic [2:0]            hist_idx;      // history read index

  // picks the message code from the mains flags
  function automatic logic [7:0] msg_pick(input logic uv, input logic lf, input logic of);
    if (uv) begin
      msg_pick = `DFSH_FC_UNDERVOLT;
    end else if (lf) begin
      msg_pick = `DFSH_FC_UNDERFREQ;
    end else if (of) begin
      msg_pick = `DFSH_FC_OVERFREQ;
    end else begin
      msg_pick = `DFSH_FC_NONE;
    end
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d      = s_q;
    hist_wr  = 1'b0;
    wr_code  = `DFSH_FC_NONE;
    hist_idx = 3'(i_addr - `DFSH_REG_HIST_FIRST);
    // two-stage sync, third stage for edges
    s_d.p1 = i_pins;
    s_d.p2 = s_q.p1;
    s_d.p3 = s_q.p2;
    zc_edge    = s_q.p2.zero_cross & ~s_q.p3.zero_cross;
    param_edge = s_q.p2.param_load & ~s_q.p3.param_load;
    ack = (i_wr && i_addr == `DFSH_REG_CTRL && i_wdata[`DFSH_CTRL_ACK]) ||
          (s_q.p2.trip_reset & ~s_q.p3.trip_reset);

    // millisecond prescaler
    ms_tick = (s_q.ms_cnt == 17'(P_MS_CYC - 1));
    s_d.ms_cnt = ms_tick ? 17'h0 : s_q.ms_cnt + 17'h1;

    // mains period measurement
    if (zc_edge) begin
      s_d.per_cnt = 22'h0;
      s_d.lf      = s_q.per_cnt > 22'(P_LF_CYC);                 // RULE_16
      s_d.of      = s_q.per_cnt < 22'(P_OF_CYC);                 // RULE_17
      s_d.uv      = 1'b0;
    end else if (s_q.per_cnt == 22'(P_UV_CYC)) begin
      s_d.uv      = 1'b1;                                        // RULE_18
    end else begin
      s_d.per_cnt = s_q.per_cnt + 22'h1;
    end

    // external trip with selectable polarity
    ext_act = s_q.p2.ext_trip ^ s_q.ext_pol;                     // RULE_19

    // overload: sustained overcurrent or too many accelerations
    if (!s_q.p2.over_rated) begin
      s_d.ovl_ms = 16'h0;
    end else if (ms_tick && s_q.ovl_ms != `DFSH_OVLD_TIME_MS) begin
      s_d.ovl_ms = s_q.ovl_ms + 16'h1;
    end
    if (ms_tick) begin
      s_d.acc_dec = (s_q.acc_dec == `DFSH_ACC_DECAY_MS) ? 10'h0 : s_q.acc_dec + 10'h1;
    end
    if (s_q.p2.oc_accel && !s_q.p3.oc_accel && s_q.acc_cnt != `DFSH_ACC_MAX) begin
      s_d.acc_cnt = s_q.acc_cnt + 3'h1;
    end else if (ms_tick && s_q.acc_dec == `DFSH_ACC_DECAY_MS && s_q.acc_cnt != 3'h0) begin
      s_d.acc_cnt = s_q.acc_cnt - 3'h1;
    end
    ovl_trip = (s_q.ovl_ms == `DFSH_OVLD_TIME_MS) ||
               (s_q.acc_cnt == `DFSH_ACC_MAX);                   // RULE_20

    // blocking: standstill current above threshold too long
    blk_cond = s_q.p2.standstill && (i_arm_current > s_q.blk_cur);
    if (!blk_cond) begin
      s_d.blk_ms = 16'h0;
    end else if (ms_tick && s_q.blk_ms != 16'hffff) begin
      s_d.blk_ms = s_q.blk_ms + 16'h1;
    end
    blk_trip = blk_cond && (s_q.blk_ms > s_q.blk_time);          // RULE_21

    // trip source priority
    trip_src_any = ext_act | ovl_trip | blk_trip;
    if (ext_act) begin
      trip_new = `DFSH_FC_EXT_TRIP;
    end else if (blk_trip) begin
      trip_new = `DFSH_FC_BLOCKED;
    end else begin
      trip_new = `DFSH_FC_OVERLOAD;
    end

    // trip latch
    case (s_q.trip_st)
      dfsh_pkg::DFSH_T_OK: begin
        if (trip_src_any) begin
          s_d.trip_st   = dfsh_pkg::DFSH_T_TRIPPED;
          s_d.trip_code = trip_new;
        end
      end
      dfsh_pkg::DFSH_T_TRIPPED: begin
        // acknowledge refused while a source is still active
        if (ack && !trip_src_any) begin                          // RULE_22
          s_d.trip_st   = dfsh_pkg::DFSH_T_OK;
          s_d.trip_code = `DFSH_FC_NONE;
          hist_wr       = 1'b1;                                  // RULE_13
          wr_code       = s_q.trip_code;
        end
      end
      default: s_d.trip_st = dfsh_pkg::DFSH_T_OK;
    endcase

    // messages clear themselves; recorded when gone, unless a trip is recorded in the same cycle
    msg_now = msg_pick(s_q.uv, s_q.lf, s_q.of);                  // RULE_23
    s_d.msg_code = msg_now;
    if (!hist_wr && s_q.msg_code != `DFSH_FC_NONE && msg_now == `DFSH_FC_NONE) begin
      hist_wr = 1'b1;                                            // RULE_13
      wr_code = s_q.msg_code;
    end
    warn_now = (s_q.ovl_ms != 16'h0 || s_q.acc_cnt != 3'h0) ? `DFSH_FC_OVERLOAD : `DFSH_FC_NONE;

    // history shift, oldest entry falls off
    if (hist_wr) begin
      for (int i = 7; i > 0; i--) begin
        s_d.hist[i] = s_q.hist[i-1];                             // RULE_14 RULE_24
      end
      s_d.hist[0] = wr_code;                                     // RULE_11
    end

    // power-up conditions for ready
    if (s_q.p2.link_up) begin
      s_d.link_seen = 1'b1;
    end
    if (s_q.p2.field_ok) begin
      s_d.field_built = 1'b1;
    end

    // brief ready drop
    if (param_edge || (s_d.uv && !s_q.uv)) begin
      s_d.drop_ms = `DFSH_DROP_MS;                               // RULE_04 RULE_05
    end else if (ms_tick && s_q.drop_ms != 8'h0) begin
      s_d.drop_ms = s_q.drop_ms - 8'h1;
    end

    // ready indication
    s_d.ready = (s_q.trip_st == dfsh_pkg::DFSH_T_OK) &&
                !(s_q.p2.ctrl_enable_sw && !s_q.p2.torque_ok) &&  // RULE_01
                !s_q.p2.supply_loss &&                            // RULE_01
                (!s_q.link_chk || s_q.link_seen) &&               // RULE_02
                s_q.field_built &&                                // RULE_03
                (s_q.drop_ms == 8'h0);                            // RULE_04 RULE_05

    // inhibit sources and pulse suppression
    s_d.inh_disp = {s_q.trip_st == dfsh_pkg::DFSH_T_TRIPPED,     // RULE_22
                    msg_now != `DFSH_FC_NONE,                    // RULE_23
                    s_q.p2.mains_ov, s_q.p2.mains_uv,            // RULE_08
                    s_q.p2.inhibit_src,
                    !s_q.p2.ctrl_enable_sw};                     // RULE_07
    s_d.inhibit = |s_d.inh_disp;                                 // RULE_07
    s_d.fire    = s_d.inhibit ? 6'h00 : i_fire;                  // RULE_09
    s_d.cur_lim = s_q.p2.speed_at_limit;                         // RULE_06
    s_d.fail    = (s_q.trip_st == dfsh_pkg::DFSH_T_TRIPPED) ||
                  (msg_now != `DFSH_FC_NONE) || (warn_now != `DFSH_FC_NONE);

    // register writes
    if (i_wr) begin
      if (i_addr == `DFSH_REG_CTRL) begin
        s_d.link_chk = i_wdata[`DFSH_CTRL_LINK_CHK];
        s_d.ext_pol  = i_wdata[`DFSH_CTRL_EXT_POL];
      end else if (i_addr == `DFSH_REG_BLK_TIME) begin
        s_d.blk_time = i_wdata;
      end else if (i_addr == `DFSH_REG_BLK_CUR) begin
        s_d.blk_cur = i_wdata[11:0];
      end
    end

    // register reads, data one cycle later
    s_d.rdata = 16'h0000;
    if (i_rd) begin
      if (i_addr == `DFSH_REG_CTRL) begin
        s_d.rdata = {13'h0, 1'b0, s_q.ext_pol, s_q.link_chk};
      end else if (i_addr == `DFSH_REG_BLK_TIME) begin
        s_d.rdata = s_q.blk_time;
      end else if (i_addr == `DFSH_REG_BLK_CUR) begin
        s_d.rdata = {4'h0, s_q.blk_cur};
      end else if (i_addr == `DFSH_REG_STATUS) begin
        s_d.rdata = {10'h0, s_q.fail, msg_now != `DFSH_FC_NONE,   // RULE_10
                     s_q.trip_st == dfsh_pkg::DFSH_T_TRIPPED,
                     s_q.cur_lim, s_q.inhibit, s_q.ready};
      end else if (i_addr == `DFSH_REG_MSG) begin
        s_d.rdata = {8'h00, msg_now};                            // RULE_10
      end else if (i_addr == `DFSH_REG_WARN) begin
        s_d.rdata = {8'h00, warn_now};                           // RULE_10
      end else if (i_addr == `DFSH_REG_FAULT) begin
        s_d.rdata = {8'h00, s_q.trip_code};                      // RULE_15
      end else if (i_addr == `DFSH_REG_INH_DISP) begin
        s_d.rdata = {8'h00, s_q.inh_disp};                       // RULE_07
      end else if (i_addr >= `DFSH_REG_HIST_FIRST && i_addr <= `DFSH_REG_HIST_LAST) begin
        s_d.rdata = {8'h00, s_q.hist[hist_idx]};                 // RULE_12 RULE_15
      end
    end

    // synchronous reset
    if (i_rst) begin
      s_d          = '0;                                         // RULE_25
      s_d.trip_st  = dfsh_pkg::DFSH_T_OK;
      s_d.inhibit  = 1'b1;
      s_d.blk_time = `DFSH_RST_BLK_TIME;
      s_d.blk_cur  = `DFSH_RST_BLK_CUR;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    s_q <= s_d;
  end

  // outputs straight from flip-flops
  assign o_rdata              = s_q.rdata;
  assign o_drive_ready        = s_q.ready;
  assign o_pulse_inhibit      = s_q.inhibit;
  assign o_current_limit_flag = s_q.cur_lim;
  assign o_fault_active       = s_q.fail;
  assign o_fire               = s_q.fire;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  sequence seq_param_load;
    param_edge;
  endsequence

  sequence seq_ready_low;
    ##2 !o_drive_ready;
  endsequence

  a_fire_blocked: assert property ( // RULE_09
    o_pulse_inhibit |-> (o_fire == 6'h00))
    else $error("ignition pulse while inhibited");

  a_ready_drop: assert property ( // RULE_04
    seq_param_load |-> seq_ready_low)
    else $error("ready not dropped on parameter load");

  a_trip_ready: assert property ( // RULE_22
    (s_q.trip_st == dfsh_pkg::DFSH_T_TRIPPED) |=> !o_drive_ready && o_pulse_inhibit)
    else $error("ready or release during trip");

  a_ack_refused: assert property ( // RULE_22
    (s_q.trip_st == dfsh_pkg::DFSH_T_TRIPPED) && trip_src_any |=>
      (s_q.trip_st == dfsh_pkg::DFSH_T_TRIPPED))
    else $error("trip released with active source");

  a_hist_shift: assert property ( // RULE_24
    hist_wr |=> (s_q.hist[0] == $past(wr_code)) && (s_q.hist[1] == $past(s_q.hist[0])))
    else $error("history not shifted");

  a_hist_oldest: assert property ( // RULE_14
    hist_wr |=> (s_q.hist[7] == $past(s_q.hist[6])))
    else $error("oldest entry not replaced");

  a_hist_hold: assert property ( // RULE_13
    !hist_wr |=> $stable(s_q.hist))
    else $error("history changed without write");

  a_uv_inhibit: assert property ( // RULE_08
    s_q.p2.mains_uv || s_q.p2.mains_ov |=> o_pulse_inhibit)
    else $error("no inhibit on mains voltage fault");

  a_cur_limit: assert property ( // RULE_06
    s_q.p2.speed_at_limit |=> o_current_limit_flag)
    else $error("current limit flag missing");

  a_hist_read: assert property ( // RULE_12
    i_rd && i_addr == `DFSH_REG_HIST_FIRST |=> o_rdata == {8'h00, $past(s_q.hist[0])})
    else $error("history read mismatch");

  a_uv_timeout: assert property ( // RULE_18
    !zc_edge && s_q.per_cnt == 22'(P_UV_CYC) |=> s_q.uv)
    else $error("undervoltage not raised");

endmodule

// [verification/dfsh_mains_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// mains model: one zero-crossing pulse per period, still at period 0
// ----------------------------------------------------------------
module dfsh_mains_model (
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic [15:0] i_period,
  output logic             o_zero_cross
);
  logic [15:0] cnt_q;  // cycles since the last crossing

  // pulse is four cycles wide so the pin synchroniser cannot miss it
  always_ff @(posedge i_clock) begin
    if (i_rst || i_period == 16'h0) begin
      cnt_q        <= 16'h0;
      o_zero_cross <= 1'b0;
    end else begin
      cnt_q        <= (cnt_q + 16'h1 >= i_period) ? 16'h0 : cnt_q + 16'h1;
      o_zero_cross <= (cnt_q < 16'h4);
    end
  end
endmodule

// [verification/dfsh_top_bench.sv]
`timescale 1ns/1ps
module dfsh_top_bench;
  logic                 i_clock;
  logic                 i_rst;
  dfsh_pkg::dfsh_pins_t pins;    // pins driven by the bench
  dfsh_pkg::dfsh_pins_t pins_w;  // pins with the mains crossing merged
  logic                 zc;      // crossing from the mains model
  logic [15:0]          period;  // mains period in cycles
  logic [11:0]          i_arm_current;
  logic [5:0]           i_fire;
  logic [7:0]           i_addr;
  logic [15:0]          i_wdata;
  logic                 i_wr;
  logic                 i_rd;
  logic [15:0]          o_rdata;
  logic                 o_drive_ready;
  logic                 o_pulse_inhibit;
  logic                 o_current_limit_flag;
  logic                 o_fault_active;
  logic [5:0]           o_fire;
  int                   fail_count;
  int                   n_tests;
  int                   cyc;

  // ----------------------------------------------------------------
  // design, mains model, clock and timeout
  // ----------------------------------------------------------------
  always_comb begin
    pins_w            = pins;
    pins_w.zero_cross = zc;
  end

  dfsh_top #(.P_MS_CYC(10), .P_UV_CYC(200), .P_LF_CYC(170), .P_OF_CYC(127)) u_dfsh_top (
    .i_clock(i_clock), .i_rst(i_rst), .i_pins(pins_w), .i_arm_current(i_arm_current),
    .i_fire(i_fire), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_drive_ready(o_drive_ready), .o_pulse_inhibit(o_pulse_inhibit),
    .o_current_limit_flag(o_current_limit_flag), .o_fault_active(o_fault_active), .o_fire(o_fire));

  dfsh_mains_model u_dfsh_mains_model (.i_clock(i_clock), .i_rst(i_rst), .i_period(period), .o_zero_cross(zc));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // hang guard, far above the expected run length
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task report_and_stop();
    if (fail_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge i_clock);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), exp, o_rdata);
  endtask

  // bounded wait for ready (sel 1) or inhibit (sel 0) to reach v
  task wt(input bit sel, input logic v);
    int n;
    n = 0;
    while (((sel ? o_drive_ready : o_pulse_inhibit) !== v) && n < 3000) begin
      @(posedge i_clock);
      #1;
      n++;
    end
    chk(sel ? "ready" : "inhibit", {15'h0, v}, {15'h0, sel ? o_drive_ready : o_pulse_inhibit});
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    fail_count = 0;
    n_tests = 0;
    cyc = 0;
    pins = '0;
    pins.ctrl_enable_sw = 1'b1;
    pins.torque_ok = 1'b1;
    period = 16'h0096;
    i_arm_current = 12'h000;
    i_fire = 6'h2a;
    i_addr = 8'h00;
    i_wdata = 16'h0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_rst = 1'b1;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    wr(8'h00, 16'h0001);  // link check on
    for (int k = 0; k < 8; k++) rd(8'h10 + k[7:0], 16'h0000);
    rd(8'h02, 16'h0800);
    rd(8'h20, 16'h0000);
    repeat (300) @(posedge i_clock);
    chk("ready", 16'h0000, {15'h0, o_drive_ready});
    @(posedge i_clock) pins.link_up <= 1'b1;
    repeat (300) @(posedge i_clock);
    chk("ready", 16'h0000, {15'h0, o_drive_ready});
    @(posedge i_clock) pins.field_ok <= 1'b1;
    wt(1, 1'b1);
    wt(0, 1'b0);
    chk("fire", 16'h002a, {10'h0, o_fire});
    chk("fail", 16'h0000, {15'h0, o_fault_active});
    rd(8'h03, 16'h0001);
    @(posedge i_clock) pins.speed_at_limit <= 1'b1;
    repeat (6) @(posedge i_clock);
    chk("limit", 16'h0001, {15'h0, o_current_limit_flag});
    rd(8'h03, 16'h0005);
    @(posedge i_clock) pins.speed_at_limit <= 1'b0;
    @(posedge i_clock) pins.inhibit_src <= 3'h1;
    wt(0, 1'b1);
    chk("fire", 16'h0000, {10'h0, o_fire});
    rd(8'h07, 16'h0002);
    @(posedge i_clock) pins.inhibit_src <= 3'h0;
    wt(0, 1'b0);
    @(posedge i_clock) pins.param_load <= 1'b1;
    wt(1, 1'b0);
    @(posedge i_clock) pins.param_load <= 1'b0;
    wt(1, 1'b1);
    // mains frequency messages release themselves
    @(posedge i_clock) period <= 16'h00be;
    wt(0, 1'b1);
    rd(8'h04, 16'h0001);
    @(posedge i_clock) period <= 16'h0096;
    wt(0, 1'b0);
    @(posedge i_clock) period <= 16'h006e;
    wt(0, 1'b1);
    rd(8'h04, 16'h0002);
    @(posedge i_clock) period <= 16'h0096;
    wt(0, 1'b0);
    // external trips, the last one through the active-low polarity
    for (int i = 0; i < 7; i++) begin
      if (i == 6) begin
        wr(8'h00, 16'h0003);
      end else begin
        @(posedge i_clock) pins.ext_trip <= 1'b1;
      end
      wt(0, 1'b1);
      rd(8'h06, 16'h0004);
      wr(8'h00, {13'h0, 1'b1, (i == 6), 1'b1});
      rd(8'h06, 16'h0004);
      rd(8'h10, (i == 0) ? 16'h0002 : 16'h0004);
      @(posedge i_clock) pins.ext_trip <= (i == 6);
      repeat (5) @(posedge i_clock);
      wr(8'h00, {13'h0, 1'b1, (i == 6), 1'b1});
      wt(0, 1'b0);
    end
    for (int k = 0; k < 8; k++) rd(8'h10 + k[7:0], (k == 7) ? 16'h0002 : 16'h0004);
    wt(1, 1'b1);
    @(posedge i_clock) pins.torque_ok <= 1'b0;
    wt(1, 1'b0);
    @(posedge i_clock) pins.torque_ok <= 1'b1;
    wt(1, 1'b1);
    @(posedge i_clock) pins.supply_loss <= 1'b1;
    wt(1, 1'b0);
    @(posedge i_clock) pins.supply_loss <= 1'b0;
    @(posedge i_clock) pins.mains_uv <= 1'b1;
    wt(0, 1'b1);
    @(posedge i_clock) pins.mains_uv <= 1'b0;
    wt(0, 1'b0);
    @(posedge i_clock) pins.mains_ov <= 1'b1;
    wt(0, 1'b1);
    @(posedge i_clock) pins.mains_ov <= 1'b0;
    wt(0, 1'b0);
    // blocking: short time, low current threshold
    wr(8'h01, 16'h0003);
    rd(8'h01, 16'h0003);
    wr(8'h02, 16'h0100);
    @(posedge i_clock) begin
      pins.standstill <= 1'b1;
      i_arm_current   <= 12'h200;
    end
    repeat (10) @(posedge i_clock);
    chk("inhibit", 16'h0000, {15'h0, o_pulse_inhibit});
    wt(0, 1'b1);
    rd(8'h06, 16'h0006);
    @(posedge i_clock) pins.standstill <= 1'b0;
    repeat (5) @(posedge i_clock);
    wr(8'h00, 16'h0007);
    wt(0, 1'b0);
    // four overcurrent accelerations in quick succession
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clock) pins.oc_accel <= 1'b1;
      repeat (4) @(posedge i_clock);
      pins.oc_accel <= 1'b0;
      repeat (4) @(posedge i_clock);
    end
    wt(0, 1'b1);
    rd(8'h06, 16'h0005);
    chk("fail", 16'h0001, {15'h0, o_fault_active});
    rd(8'h05, 16'h0005);
    @(posedge i_clock) period <= 16'h0000;
    repeat (400) @(posedge i_clock);
    rd(8'h04, 16'h0003);
    report_and_stop();
  end
endmodule
